// file: sim/master_trip_handler_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module master_trip_handler_tb_top;
  // A short millisecond keeps pulse checks within a few hundred cycles.
  localparam int MS = 10;
  logic clk = 1'h0;
  logic srst = 1'h1;
  trip_pkg::axi_req_type req = '0;
  trip_pkg::axi_rsp_type rsp;
  logic [3:0] src = 4'h0;
  logic inhibit = 1'h0;
  logic lk_clr = 1'h0;
  logic request;
  logic trip;
  logic lock;
  logic [31:0] rnd = 32'h0000_034c;
  logic [31:0] rd;
  int n_errors = 0;
  int n_compared = 0;
  int len;
  int p;
  int k;

  trip_upstream_model trip_upstream_model_i (.source_trip(src), .trip_request(request));
  master_trip_handler #(.MS_CYCLES(MS)) master_trip_handler_i (.clk(clk), .srst(srst),
    .axi_req(req), .axi_rsp(rsp), .trip_request_in(request), .inhibit_in(inhibit),
    .lockout_clear_in(lk_clr), .trip_out(trip), .lockout_out(lock));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic int exp_len(input int h, input int q);
    return (h > q * MS) ? h : q * MS;
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge clk);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid === 1'h1) begin
        req.bready <= 1'h0;
        check({30'h0, rsp.bresp}, {30'h0, e});
        return;
      end
    end
    timed_out();
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [1:0] e);
    int i;
    @(posedge clk);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid === 1'h1) begin
        req.rready <= 1'h0;
        rd = rsp.rdata;
        check({30'h0, rsp.rresp}, {30'h0, e});
        return;
      end
    end
    timed_out();
  endtask

  task automatic drive(input logic [3:0] s, input logic i, input logic c);
    @(posedge clk);
    src <= s;
    inhibit <= i;
    lk_clr <= c;
  endtask

  // Samples just after an edge, once the outputs have settled.
  task automatic outs(input logic [1:0] e);
    @(posedge clk);
    #1;
    check({30'h0, lock, trip}, {30'h0, e});
  endtask

  task automatic pulse_len(input int h, output int n);
    int i;
    drive(rnd[11:8] | 4'h1, 1'h0, 1'h0);
    n = 0;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (i == h - 1) src <= 4'h0;
      if (trip === 1'h1) n++;
      else if (n > 0 && i >= h) return;
    end
    timed_out();
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    axi_read(trip_pkg::CTRL_ADDR, trip_pkg::RESP_OKAY);
    check(rd, 32'h0000_0003);
    axi_read(trip_pkg::PULSE_ADDR, trip_pkg::RESP_OKAY);
    check(rd, 32'h0000_00fa);
    axi_read(8'h10, trip_pkg::RESP_SLVERR);
    axi_write(8'h10, 32'h0000_0001, trip_pkg::RESP_SLVERR);
    axi_write(trip_pkg::PULSE_ADDR, 32'h0000_ffff, trip_pkg::RESP_OKAY);
    axi_read(trip_pkg::PULSE_ADDR, trip_pkg::RESP_OKAY);
    check(rd, 32'h0000_ea60);
    repeat (6) begin
      rnd = lfsr(rnd);
      p = 1 + int'(rnd[1:0]);
      axi_write(trip_pkg::PULSE_ADDR, 32'(p), trip_pkg::RESP_OKAY);
      pulse_len(1 + int'(rnd[7:2]), len);
      check({31'h0, len >= exp_len(1 + int'(rnd[7:2]), p) &&
        len <= exp_len(1 + int'(rnd[7:2]), p) + 1}, 32'h1);
    end
    drive(4'h2, 1'h0, 1'h0);
    drive(4'h0, 1'h0, 1'h0);
    repeat (3) @(posedge clk);
    drive(4'h0, 1'h1, 1'h0);
    outs(2'h0);
    drive(4'h0, 1'h0, 1'h0);
    outs(2'h0);
    axi_write(trip_pkg::CTRL_ADDR, 32'h0000_0005, trip_pkg::RESP_OKAY);
    for (k = 0; k < 3; k++) begin
      drive(4'h8, 1'h0, 1'h0);
      drive(4'h0, 1'h0, 1'h0);
      repeat (20) @(posedge clk);
      outs(2'h1);
      if (k == 2) begin
        drive(4'h0, 1'h0, 1'h1);
        drive(4'h0, 1'h0, 1'h0);
      end else begin
        axi_write(trip_pkg::CLEAR_ADDR, 32'(k + 1), trip_pkg::RESP_OKAY);
      end
      outs(2'h0);
    end
    // Lockout ignores the remote clear and survives inhibit, which only masks it.
    axi_write(trip_pkg::CTRL_ADDR, 32'h0000_0007, trip_pkg::RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      drive(4'h4, 1'h0, 1'h0);
      drive(4'h0, 1'h0, 1'h0);
      repeat (20) @(posedge clk);
      outs(2'h3);
      axi_read(trip_pkg::STATUS_ADDR, trip_pkg::RESP_OKAY);
      check(rd, 32'h0000_0007);
      axi_write(trip_pkg::CLEAR_ADDR, 32'h0000_0002, trip_pkg::RESP_OKAY);
      outs(2'h3);
      drive(4'h0, 1'h1, 1'h0);
      outs(2'h0);
      drive(4'h0, 1'h0, 1'h0);
      outs(2'h3);
      if (k == 0) begin
        drive(4'h0, 1'h0, 1'h1);
        drive(4'h0, 1'h0, 1'h0);
      end else begin
        axi_write(trip_pkg::CLEAR_ADDR, 32'h0000_0001, trip_pkg::RESP_OKAY);
      end
      outs(2'h0);
    end
    axi_write(trip_pkg::CTRL_ADDR, 32'h0000_0006, trip_pkg::RESP_OKAY);
    drive(4'hf, 1'h0, 1'h0);
    repeat (5) @(posedge clk);
    outs(2'h0);
    drive(4'h0, 1'h0, 1'h0);
    axi_write(trip_pkg::STATUS_ADDR, 32'h0000_003f, trip_pkg::RESP_OKAY);
    // Mode code zero falls back to non-latched behaviour, so a short request starts a pulse.
    axi_write(trip_pkg::CTRL_ADDR, 32'h0000_0001, trip_pkg::RESP_OKAY);
    drive(4'h1, 1'h0, 1'h0);
    drive(4'h0, 1'h0, 1'h0);
    outs(2'h1);
    stop_test();
  end
endmodule

`default_nettype wire

// file: sim/trip_upstream_model.sv
`timescale 1ns/10ps
`default_nettype none

// Several protection sources share one request line, so they are merged before the block.
module trip_upstream_model (
  input wire logic [3:0] source_trip,
  output logic trip_request
);
  assign trip_request = |source_trip;
endmodule

`default_nettype wire

// file: src/master_trip_handler.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module master_trip_handler #(
  parameter int MS_CYCLES = trip_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire trip_pkg::axi_req_type axi_req,
  output trip_pkg::axi_rsp_type axi_rsp,
  input wire logic trip_request_in,
  input wire logic inhibit_in,
  input wire logic lockout_clear_in,
  output logic trip_out,
  output logic lockout_out
);

  trip_pkg::trip_state_type st_q;
  trip_pkg::trip_state_type st_d;

  logic wr_fire;
  logic local_clr;
  logic remote_clr;
  logic restart;
  logic tick;
  logic rise;
  logic active;
  logic [15:0] pulse_new;

  // A write is performed once both address and data are held and the old response is gone.
  assign wr_fire = st_q.aw_have && st_q.w_have && !st_q.rsp.bvalid;
  assign local_clr = wr_fire && st_q.awaddr == trip_pkg::CLEAR_ADDR && st_q.wstrb[0] &&
                     st_q.wdata[trip_pkg::CLR_LOCAL_BIT];
  assign remote_clr = wr_fire && st_q.awaddr == trip_pkg::CLEAR_ADDR && st_q.wstrb[0] &&
                      st_q.wdata[trip_pkg::CLR_REMOTE_BIT];
  // The request comes from logic on this clock, so it is used without synchronisers.
  assign rise = trip_request_in && !st_q.req_q;
  assign active = st_q.op && !inhibit_in;

  trip_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .tick(tick)
  );

  always_comb begin
    st_d = st_q;
    restart = 1'b0;
    pulse_new = st_q.pulse_ms;
    st_d.req_q = trip_request_in;

    // Write channel capture; address and data may come in either order.
    if (axi_req.awvalid && st_q.rsp.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_q.rsp.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = axi_req.wdata;
      st_d.wstrb = axi_req.wstrb;
    end
    if (axi_req.bready && st_q.rsp.bvalid) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = trip_pkg::RESP_OKAY;
      case (st_q.awaddr)
        trip_pkg::CTRL_ADDR: begin
          if (st_q.wstrb[0]) begin
            st_d.op = st_q.wdata[trip_pkg::CTRL_OP_BIT];
            st_d.mode = st_q.wdata[trip_pkg::CTRL_MODE_LSB +: 2];
          end
        end
        trip_pkg::PULSE_ADDR: begin
          if (st_q.wstrb[0]) begin
            pulse_new[7:0] = st_q.wdata[7:0];
          end
          if (st_q.wstrb[1]) begin
            pulse_new[15:8] = st_q.wdata[15:8];
          end
          // Values past the top of the range are clamped rather than refused.
          if (pulse_new > trip_pkg::PULSE_MAX) begin
            pulse_new = trip_pkg::PULSE_MAX;
          end
          st_d.pulse_ms = pulse_new;
        end
        trip_pkg::CLEAR_ADDR: begin
        end
        trip_pkg::STATUS_ADDR: begin
        end
        default: begin
          st_d.rsp.bresp = trip_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Ready stays low while a response is pending, so a second write cannot overtake the first.
    st_d.rsp.awready = !st_d.aw_have && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.w_have && !st_d.rsp.bvalid;

    // Read channel: one read at a time, answered the cycle after the address is taken.
    if (axi_req.rready && st_q.rsp.rvalid) begin
      st_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_q.rsp.arready) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rresp = trip_pkg::RESP_OKAY;
      st_d.rsp.rdata = '0;
      case (axi_req.araddr)
        trip_pkg::CTRL_ADDR: begin
          st_d.rsp.rdata[trip_pkg::CTRL_OP_BIT] = st_q.op;
          st_d.rsp.rdata[trip_pkg::CTRL_MODE_LSB +: 2] = st_q.mode;
        end
        trip_pkg::PULSE_ADDR: begin
          st_d.rsp.rdata[15:0] = st_q.pulse_ms;
        end
        trip_pkg::CLEAR_ADDR: begin
        end
        trip_pkg::STATUS_ADDR: begin
          // The live inputs are shown so that software can see what the outputs hide.
          st_d.rsp.rdata[trip_pkg::STAT_TRIP_BIT] = st_q.trip;
          st_d.rsp.rdata[trip_pkg::STAT_LOCK_BIT] = st_q.lock_out;
          st_d.rsp.rdata[trip_pkg::STAT_LATCH_BIT] = st_q.latch;
          st_d.rsp.rdata[trip_pkg::STAT_TIMER_BIT] = st_q.cnt != '0;
          st_d.rsp.rdata[trip_pkg::STAT_INHIBIT_BIT] = inhibit_in;
          st_d.rsp.rdata[trip_pkg::STAT_REQ_BIT] = trip_request_in;
        end
        default: begin
          st_d.rsp.rresp = trip_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_d.rsp.arready = !st_d.rsp.rvalid;

    // Trip handling. In every mode a new request wins over a clear in the same cycle.
    if (!st_q.op) begin
      st_d.latch = 1'b0;
      st_d.lockout = 1'b0;
      st_d.cnt = '0;
    end else if (inhibit_in) begin
      // Held latches survive an inhibit; the outputs are blocked and the timer is cleared, and latch and lockout are neither set nor cleared.
      st_d.cnt = '0;
    end else begin
      case (st_q.mode)
        trip_pkg::MODE_LATCHED: begin
          st_d.cnt = '0;
          st_d.lockout = 1'b0;
          if (local_clr || lockout_clear_in || remote_clr) begin
            st_d.latch = 1'b0;
          end
          if (trip_request_in) begin
            st_d.latch = 1'b1;
          end
        end
        trip_pkg::MODE_LOCKOUT: begin
          st_d.cnt = '0;
          if (local_clr || lockout_clear_in) begin
            st_d.latch = 1'b0;
            st_d.lockout = 1'b0;
          end
          if (trip_request_in) begin
            st_d.latch = 1'b1;
            st_d.lockout = 1'b1;
          end
        end
        default: begin
          st_d.latch = 1'b0;
          st_d.lockout = 1'b0;
          if (rise) begin
            st_d.cnt = st_q.pulse_ms;
            restart = 1'b1;
          end else if (tick && st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 16'h0001;
          end
        end
      endcase
    end

    // Outputs follow the next state, so each one changes one edge after its cause.
    if (st_q.mode == trip_pkg::MODE_LATCHED || st_q.mode == trip_pkg::MODE_LOCKOUT) begin
      st_d.trip = active && st_d.latch;
    end else begin
      st_d.trip = active && (trip_request_in || st_d.cnt != '0);
    end
    st_d.lock_out = active && st_d.lockout;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= trip_pkg::STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign axi_rsp = st_q.rsp;
  assign trip_out = st_q.trip;
  assign lockout_out = st_q.lock_out;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic nl_run;
  assign nl_run = active && st_q.mode == trip_pkg::MODE_NON_LATCHED;

  a_op_off_quiet: assert property (!st_q.op |=> !trip_out && !lockout_out)
    else $error("output active while operation is off");
  a_inhibit_blocks: assert property (inhibit_in |=> !trip_out && !lockout_out)
    else $error("output active while inhibited");
  a_inhibit_timer_idle: assert property (inhibit_in |=> st_q.cnt == '0)
    else $error("pulse timer not idle after inhibit");
  a_pulse_starts: assert property (nl_run && rise |=> trip_out && st_q.cnt == $past(st_q.pulse_ms))
    else $error("pulse did not start with the loaded time");
  a_pulse_holds: assert property (nl_run && st_q.cnt > 16'h0001 ##1 nl_run |-> trip_out)
    else $error("trip fell while the pulse timer was running");
  a_timer_mode_only: assert property (st_q.mode != trip_pkg::MODE_NON_LATCHED
    && st_q.mode != '0 |=> st_q.cnt == '0)
    else $error("pulse timer ran outside non-latched mode");
  a_latch_holds: assert property (st_q.latch && trip_out
    && st_q.mode == trip_pkg::MODE_LATCHED && !local_clr
    && !remote_clr && !lockout_clear_in && active ##1 active |-> trip_out)
    else $error("latched trip dropped without a clear");
  a_latch_local_clear: assert property (st_q.mode == trip_pkg::MODE_LATCHED && active
    && lockout_clear_in && !trip_request_in |=> !trip_out)
    else $error("local clear did not release latched trip");
  a_lockout_keeps: assert property (lockout_out && active
    && st_q.mode == trip_pkg::MODE_LOCKOUT && !local_clr && !lockout_clear_in
    ##1 active && st_q.mode == trip_pkg::MODE_LOCKOUT |-> lockout_out && trip_out)
    else $error("lockout released by other than a local clear");
  a_lockout_sets: assert property (st_q.mode == trip_pkg::MODE_LOCKOUT && active
    && trip_request_in |=> lockout_out ##1 lockout_out || !$past(active)
    || $past(local_clr) || $past(lockout_clear_in)
    || $past(st_q.mode) != trip_pkg::MODE_LOCKOUT)
    else $error("lockout did not set or hold after a request");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !trip_out && !lockout_out
    && st_q.cnt == '0 && !st_q.latch)
    else $error("state not cleared by reset");

  // The timer, latch and lockout state are watched directly, since the outputs mask them.
  // A hold that broke under inhibit would otherwise stay hidden until the inhibit fell.
  a_op_off_clears: assert property (!st_q.op |=> !st_q.latch && !st_q.lockout
    && st_q.cnt == '0)
    else $error("held state survived operation off");
  a_pulse_ends: assert property (nl_run && !trip_request_in && st_q.cnt == '0
    |=> !trip_out)
    else $error("trip stayed on after the pulse ran out");
  a_timer_waits: assert property (nl_run && !rise && !tick && st_q.cnt != '0
    |=> st_q.cnt == $past(st_q.cnt))
    else $error("pulse timer moved between ticks");
  a_timer_steps: assert property (nl_run && !rise && tick && st_q.cnt != '0
    |=> st_q.cnt == $past(st_q.cnt) - 16'h0001)
    else $error("pulse timer did not step down on a tick");
  a_latch_sets: assert property (st_q.mode == trip_pkg::MODE_LATCHED && active
    && trip_request_in |=> trip_out)
    else $error("latched trip did not set on a request");
  a_latch_remote_clear: assert property (st_q.mode == trip_pkg::MODE_LATCHED && active
    && remote_clr && !trip_request_in |=> !trip_out)
    else $error("remote clear did not release latched trip");
  a_remote_ignored: assert property (st_q.mode == trip_pkg::MODE_LOCKOUT && active
    && st_q.lockout && remote_clr && !local_clr && !lockout_clear_in
    |=> lockout_out && trip_out)
    else $error("remote clear released a lockout");
  a_nl_no_lock: assert property (nl_run |=> !lockout_out)
    else $error("lockout output set outside lockout mode");
  a_lock_with_trip: assert property (lockout_out |-> trip_out)
    else $error("lockout output without trip output");
  a_inhibit_keeps_lock: assert property (st_q.op && inhibit_in && st_q.lockout
    |=> st_q.lockout)
    else $error("inhibit dropped a held lockout");
  a_inhibit_no_set: assert property (st_q.op && inhibit_in && !st_q.latch
    |=> !st_q.latch)
    else $error("latch set while inhibited");
  a_pulse_in_range: assert property (st_q.pulse_ms <= trip_pkg::PULSE_MAX)
    else $error("pulse time above its range");

  c_pulse_ends: cover property (nl_run && trip_out ##1 !trip_out);
  c_latched_clear: cover property (st_q.mode == trip_pkg::MODE_LATCHED && trip_out ##1 !trip_out);
  c_lockout_clear: cover property (lockout_out ##1 !lockout_out);
  c_remote_ignored: cover property (lockout_out && remote_clr ##1 lockout_out);
  c_inhibit_masks: cover property (inhibit_in && st_q.lockout ##2 lockout_out);

endmodule

`default_nettype wire

// file: src/trip_ms_tick.sv
`timescale 1ns/10ps
`default_nettype none

module trip_ms_tick #(
  parameter int CYCLES = trip_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);

  localparam logic [trip_pkg::CNT_W-1:0] LAST = (trip_pkg::CNT_W)'(CYCLES - 1);

  trip_pkg::tick_state_type st_q;
  trip_pkg::tick_state_type st_d;

  // A restart realigns the divider so that a fresh pulse always gets whole milliseconds.
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (restart || st_q.count == LAST) begin
      st_d.count = '0;
    end else begin
      st_d.count = st_q.count + 1'b1;
    end
    if (!restart && st_q.count == LAST) begin
      st_d.tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_tick_after_restart: assert property (restart |=> !tick [*2])
    else $error("tick came too soon after a restart");
  a_tick_single: assert property (tick && CYCLES > 1 |=> !tick)
    else $error("tick lasted more than one cycle");

endmodule

`default_nettype wire

// file: src/trip_pkg.sv
package trip_pkg;

  // Clock rate and millisecond base for the pulse timer.
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int CNT_W = 17;

  // Register map, byte addresses on the AXI4-Lite slave.
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PULSE_ADDR = 8'h04;
  localparam logic [7:0] CLEAR_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;

  // Field positions.
  localparam int CTRL_OP_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CLR_LOCAL_BIT = 0;
  localparam int CLR_REMOTE_BIT = 1;
  localparam int STAT_TRIP_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_LATCH_BIT = 2;
  localparam int STAT_TIMER_BIT = 3;
  localparam int STAT_INHIBIT_BIT = 4;
  localparam int STAT_REQ_BIT = 5;

  // Trip output modes as software writes them.
  localparam logic [1:0] MODE_NON_LATCHED = 2'h1;
  localparam logic [1:0] MODE_LATCHED = 2'h2;
  localparam logic [1:0] MODE_LOCKOUT = 2'h3;

  // Reset values and limits.
  localparam logic OP_RESET = 1'b1;
  localparam logic [1:0] MODE_RESET = MODE_NON_LATCHED;
  localparam logic [15:0] PULSE_RESET = 16'h00FA;
  localparam logic [15:0] PULSE_MAX = 16'hEA60;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic op;
    logic [1:0] mode;
    logic [15:0] pulse_ms;
    logic [15:0] cnt;
    logic req_q;
    logic latch;
    logic lockout;
    logic trip;
    logic lock_out;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_type rsp;
  } trip_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic tick;
  } tick_state_type;

  localparam trip_state_type STATE_RESET = '{
    op: OP_RESET, mode: MODE_RESET, pulse_ms: PULSE_RESET, default: '0};

endpackage
